/* core/mir_link.sv */
`default_nettype none
module mir_link (
	input  wire logic       scl,      // Serial clock from the host.
	input  wire logic       resetn,   // Asynchronous reset, active low.
	input  wire logic       link_rst, // Frame reset, active high.
	input  wire logic       sda_in,   // Data line level.
	input  wire logic [7:0] tx_byte,  // Next byte to send.
	output logic            sda_oe,   // Pull data line low.
	output logic      [7:0] rx_byte,  // Last shifted byte.
	output logic            wr_tgl,   // Toggles per written data byte.
	output logic            rd_tgl    // Toggles per loaded read byte.
);
	import mir_pkg::*;

	logic [3:0] bit_cnt;
	logic       is_addr;
	logic       selected;
	logic       rd_mode;
	logic       addr_ack;
	logic [7:0] txsh;

	// Start and stop reset the frame state; the toggles keep their phase across frames.
	always_ff @(posedge scl or posedge link_rst) begin
		if (link_rst) begin
			bit_cnt  <= 4'h0;
			rx_byte  <= 8'h00;
			is_addr  <= 1'b1;
			selected <= 1'b0;
			rd_mode  <= 1'b0;
			addr_ack <= 1'b0;
		end else if (bit_cnt == MIR_ACK_SLOT) begin
			bit_cnt <= 4'h0;
			if (selected && rd_mode && sda_in) begin
				selected <= 1'b0;
			end
		end else begin
			rx_byte  <= {rx_byte[6:0], sda_in};
			bit_cnt  <= bit_cnt + 4'h1;
			addr_ack <= is_addr && (bit_cnt == MIR_LAST_BIT);
			if (is_addr && bit_cnt == MIR_LAST_BIT) begin
				selected <= (rx_byte[6:0] == MIR_DEV_ADDR);
				rd_mode  <= sda_in;
				is_addr  <= 1'b0;
			end
		end
	end

	always_ff @(posedge scl or negedge resetn) begin
		if (!resetn) begin
			wr_tgl <= 1'b0;
		end else if (!link_rst && bit_cnt == MIR_LAST_BIT && !is_addr && selected && !rd_mode) begin
			wr_tgl <= ~wr_tgl;
		end
	end

	// Drive on the falling edge so the line is settled long before the host samples it.
	always_ff @(negedge scl or posedge link_rst) begin
		if (link_rst) begin
			sda_oe <= 1'b0;
			txsh   <= 8'h00;
		end else if (bit_cnt == MIR_ACK_SLOT) begin
			sda_oe <= selected && (!rd_mode || addr_ack);
		end else if (bit_cnt == 4'h0 && selected && rd_mode) begin
			txsh   <= {tx_byte[6:0], 1'b0};
			sda_oe <= ~tx_byte[7];
		end else if (selected && rd_mode) begin
			txsh   <= {txsh[6:0], 1'b0};
			sda_oe <= ~txsh[7];
		end else begin
			sda_oe <= 1'b0;
		end
	end

	always_ff @(negedge scl or negedge resetn) begin
		if (!resetn) begin
			rd_tgl <= 1'b0;
		end else if (!link_rst && bit_cnt == 4'h0 && selected && rd_mode) begin
			rd_tgl <= ~rd_tgl;
		end
	end
endmodule : mir_link
`default_nettype wire

/* core/mir_pkg.sv */
`default_nettype none
package mir_pkg;
	// Seven-bit bus address of the management target (A0h in eight-bit form).
	localparam logic [6:0] MIR_DEV_ADDR       = 7'h50;
	localparam logic [7:0] MIR_OFS_TYPE_LO    = 8'h00;
	localparam logic [7:0] MIR_OFS_STATUS     = 8'h02;
	localparam logic [7:0] MIR_OFS_TEMP_FLAGS = 8'h06;
	localparam logic [7:0] MIR_OFS_RAIL_FLAGS = 8'h07;
	localparam logic [7:0] MIR_OFS_MAIN_FLAGS = 8'h08;
	localparam logic [7:0] MIR_OFS_TOP_HI     = 8'h16;
	localparam logic [7:0] MIR_OFS_TOP_LO     = 8'h17;
	localparam logic [7:0] MIR_OFS_BOT_HI     = 8'h18;
	localparam logic [7:0] MIR_OFS_BOT_LO     = 8'h19;
	localparam logic [7:0] MIR_OFS_RX_HI      = 8'h1a;
	localparam logic [7:0] MIR_OFS_RX_LO      = 8'h1b;
	localparam logic [7:0] MIR_OFS_TX_HI      = 8'h1c;
	localparam logic [7:0] MIR_OFS_TX_LO      = 8'h1d;
	localparam logic [7:0] MIR_OFS_MAIN_HI    = 8'h1e;
	localparam logic [7:0] MIR_OFS_MAIN_LO    = 8'h1f;
	localparam logic [7:0] MIR_OFS_MAX_POWER  = 8'h5d;
	localparam logic [7:0] MIR_OFS_TYPE_HI    = 8'h80;
	localparam logic [7:0] MIR_OFS_NAME       = 8'h94;
	localparam logic [7:0] MIR_OFS_PART       = 8'ha8;
	localparam logic [7:0] MIR_OFS_REV        = 8'hb8;
	localparam logic [7:0] MIR_OFS_SERIAL     = 8'hc4;
	localparam logic [7:0] MIR_TEXT_LEN       = 8'h10;
	localparam logic [7:0] MIR_REV_LEN        = 8'h02;
	localparam int         MIR_POWER_POS      = 2;
	localparam int         MIR_READY_BIT      = 0;
	localparam logic [1:0] MIR_PWR_0W         = 2'h0;
	localparam logic [1:0] MIR_PWR_3P5W       = 2'h1;
	localparam logic [1:0] MIR_PWR_7W         = 2'h2;
	localparam logic [3:0] MIR_ACK_SLOT       = 4'h8;
	localparam logic [3:0] MIR_LAST_BIT       = 4'h7;
	typedef enum logic [2:0] {
		MIR_IDLE = 3'b001,
		MIR_PTR  = 3'b010,
		MIR_DATA = 3'b100
	} mir_phase_t;
endpackage : mir_pkg
`default_nettype wire

/* core/mir_regs.sv */
`default_nettype none
module mir_regs #(
	parameter logic [7:0]   MODULE_TYPE    = 8'h5a, // Arbitrary value.
	parameter logic [1:0]   MAX_POWER_CODE = mir_pkg::MIR_PWR_7W,
	parameter logic [127:0] MAKER_NAME     = "MAKER NAME      ",
	parameter logic [127:0] MAKER_PART     = "PART NUMBER     ",
	parameter logic [15:0]  MAKER_REV      = "A0",
	parameter logic [127:0] SERIAL_NUMBER  = "SERIAL0000000001"
) (
	input  wire logic        clk,             // System clock, 200 MHz.
	input  wire logic        resetn,          // Asynchronous reset, active low.
	input  wire logic        scl,             // Serial clock from the host.
	input  wire logic        sda_in,          // Data line level.
	output logic             sda_out,         // Data line drive value, always low.
	output logic             sda_oe,          // Data line pull-down enable.
	output logic             attention_out_n, // Interrupt to host, active low.
	input  wire logic        data_valid,      // Monitor values are valid.
	input  wire logic [15:0] top_temp,        // Top case, 1/256 degC signed.
	input  wire logic [15:0] bottom_temp,     // Bottom case, 1/256 degC signed.
	input  wire logic [15:0] rx_rail_volt,    // Receiver rail, 100 uV steps.
	input  wire logic [15:0] tx_rail_volt,    // Transmitter rail, 100 uV steps.
	input  wire logic [15:0] main_rail_volt,  // General rail, 100 uV steps.
	input  wire logic [7:0]  temp_cond,       // Temperature conditions, byte 6 layout.
	input  wire logic [7:0]  rail_cond,       // Rx/Tx rail conditions, byte 7 layout.
	input  wire logic [3:0]  main_rail_cond,  // General rail conditions, high first.
	input  wire logic [3:0]  tx_lane_p,       // Transmit lanes, true side.
	input  wire logic [3:0]  tx_lane_n,       // Transmit lanes, complement side.
	output logic      [3:0]  rx_lane_p,       // Receive lanes, true side.
	output logic      [3:0]  rx_lane_n        // Receive lanes, complement side.
);
	import mir_pkg::*;

	logic [3:0]  sync_q;
	logic        scl_s;
	logic        sda_s;
	logic        wr_s;
	logic        rd_s;
	logic        scl_q;
	logic        sda_q;
	logic        wr_q;
	logic        rd_q;
	logic        start_det;
	logic        stop_det;
	logic        wr_ev;
	logic        rd_ev;
	logic        link_rst;
	logic        link_wr_tgl;
	logic        link_rd_tgl;
	logic        link_sda_oe;
	logic [7:0]  link_rx_byte;
	logic [7:0]  ptr;
	logic [7:0]  tx_byte;
	mir_phase_t  phase;
	logic [7:0]  temp_flags;
	logic [7:0]  rail_flags;
	logic [3:0]  main_flags;
	logic        ready_q;
	logic [15:0] top_q;
	logic [15:0] bot_q;
	logic [15:0] rx_q;
	logic [15:0] tx_q;
	logic [15:0] main_q;

	if (MAX_POWER_CODE == 2'h3) begin : g_chk
		$error("MAX_POWER_CODE 3 has no meaning");
	end

	// The lanes are passive copper: the loop is wiring, with no register in the path.
	assign rx_lane_p = tx_lane_p;
	assign rx_lane_n = tx_lane_n;
	assign sda_out   = 1'b0;
	assign sda_oe    = link_sda_oe;

	// Picks one text byte; the first character sits in the top byte of the field.
	function automatic logic [7:0] text_byte(input logic [127:0] txt, input logic [7:0] idx);
		logic [7:0] sh;
		sh = 8'(MIR_TEXT_LEN - 8'h01 - idx);
		return txt[{sh[3:0], 3'h0} +: 8];
	endfunction : text_byte

	function automatic logic in_field(input logic [7:0] a, input logic [7:0] base,
		input logic [7:0] len);
		return (a >= base) && (a < 8'(base + len));
	endfunction : in_field

	function automatic logic [7:0] byte_at(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (in_field(a, MIR_OFS_NAME, MIR_TEXT_LEN)) begin
			v = text_byte(MAKER_NAME, 8'(a - MIR_OFS_NAME));
		end else if (in_field(a, MIR_OFS_PART, MIR_TEXT_LEN)) begin
			v = text_byte(MAKER_PART, 8'(a - MIR_OFS_PART));
		end else if (in_field(a, MIR_OFS_SERIAL, MIR_TEXT_LEN)) begin
			v = text_byte(SERIAL_NUMBER, 8'(a - MIR_OFS_SERIAL));
		end else if (a == MIR_OFS_REV) begin
			v = MAKER_REV[15:8];
		end else if (a == 8'(MIR_OFS_REV + MIR_REV_LEN - 8'h01)) begin
			v = MAKER_REV[7:0];
		end else begin
			unique case (a)
				MIR_OFS_TYPE_LO, MIR_OFS_TYPE_HI: v = MODULE_TYPE;
				MIR_OFS_STATUS:     v = {7'h00, !ready_q} << MIR_READY_BIT;
				MIR_OFS_TEMP_FLAGS: v = temp_flags;
				MIR_OFS_RAIL_FLAGS: v = rail_flags;
				MIR_OFS_MAIN_FLAGS: v = {main_flags, 4'h0};
				MIR_OFS_TOP_HI:     v = top_q[15:8];
				MIR_OFS_TOP_LO:     v = top_q[7:0];
				MIR_OFS_BOT_HI:     v = bot_q[15:8];
				MIR_OFS_BOT_LO:     v = bot_q[7:0];
				MIR_OFS_RX_HI:      v = rx_q[15:8];
				MIR_OFS_RX_LO:      v = rx_q[7:0];
				MIR_OFS_TX_HI:      v = tx_q[15:8];
				MIR_OFS_TX_LO:      v = tx_q[7:0];
				MIR_OFS_MAIN_HI:    v = main_q[15:8];
				MIR_OFS_MAIN_LO:    v = main_q[7:0];
				MIR_OFS_MAX_POWER:  v = 8'(MAX_POWER_CODE) << MIR_POWER_POS;
				default:            v = 8'h00;
			endcase
		end
		return v;
	endfunction : byte_at

	// The serial-clock side shifts bits, matches the address and acknowledges; pointer and flags live here.
	mir_link u_link (
		.scl      (scl),
		.resetn   (resetn),
		.link_rst (link_rst),
		.sda_in   (sda_in),
		.tx_byte  (tx_byte),
		.sda_oe   (link_sda_oe),
		.rx_byte  (link_rx_byte),
		.wr_tgl   (link_wr_tgl),
		.rd_tgl   (link_rd_tgl)
	);

	// The serial clock is also watched as a level here, to see start and stop.
	mir_sync #(
		.WIDTH (4)
	) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.d      ({scl, sda_in, link_wr_tgl, link_rd_tgl}),
		.q      (sync_q)
	);
	assign {scl_s, sda_s, wr_s, rd_s} = sync_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_q <= 1'b0;
			sda_q <= 1'b0;
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
			wr_q  <= wr_s;
			rd_q  <= rd_s;
		end
	end

	assign start_det = scl_s && scl_q && sda_q && !sda_s;
	assign stop_det  = scl_s && scl_q && !sda_q && sda_s;
	assign wr_ev     = wr_s ^ wr_q;
	assign rd_ev     = rd_s ^ rd_q;

	// Held through idle and released while the serial clock is low, so the
	// release never races a rising serial clock edge.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			link_rst <= 1'b1;
		end else if (start_det || stop_det) begin
			link_rst <= 1'b1;
		end else if (!scl_s) begin
			link_rst <= 1'b0;
		end
	end

	// The first written byte after an address sets the pointer; later writes
	// land on read-only bytes and are dropped.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase <= MIR_IDLE;
			ptr   <= 8'h00;
		end else if (stop_det) begin
			phase <= MIR_IDLE;
		end else if (start_det) begin
			phase <= MIR_PTR;
		end else begin
			unique case (phase)
				MIR_IDLE: phase <= MIR_IDLE;
				MIR_PTR: begin
					if (wr_ev) begin
						ptr   <= link_rx_byte;
						phase <= MIR_DATA;
					end else if (rd_ev) begin
						ptr   <= ptr + 8'h01;
						phase <= MIR_DATA;
					end
				end
				MIR_DATA: begin
					if (rd_ev) begin
						ptr <= ptr + 8'h01;
					end
				end
			endcase
		end
	end

	// The byte is staged well ahead: the link loads it nearly nine bit times later.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_byte <= 8'h00;
		end else begin
			tx_byte <= byte_at(ptr);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ready_q <= 1'b0;
			top_q   <= 16'h0000;
			bot_q   <= 16'h0000;
			rx_q    <= 16'h0000;
			tx_q    <= 16'h0000;
			main_q  <= 16'h0000;
		end else begin
			ready_q <= data_valid;
			top_q   <= top_temp;
			bot_q   <= bottom_temp;
			rx_q    <= rx_rail_volt;
			tx_q    <= tx_rail_volt;
			main_q  <= main_rail_volt;
		end
	end

	// A condition present in the clearing cycle sets the flag again, so no
	// event is lost to a read.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			temp_flags <= 8'h00;
			rail_flags <= 8'h00;
			main_flags <= 4'h0;
		end else begin
			temp_flags <= (temp_flags & ~{8{rd_ev && ptr == MIR_OFS_TEMP_FLAGS}})
				| temp_cond;
			rail_flags <= (rail_flags & ~{8{rd_ev && ptr == MIR_OFS_RAIL_FLAGS}})
				| rail_cond;
			main_flags <= (main_flags & ~{4{rd_ev && ptr == MIR_OFS_MAIN_FLAGS}})
				| main_rail_cond;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			attention_out_n <= 1'b1;
		end else begin
			attention_out_n <= !(|temp_flags || |rail_flags || |main_flags);
		end
	end

	a_attn_low_flags: assert property (@(posedge clk) disable iff (!resetn)
		(|temp_flags || |rail_flags || |main_flags) |=> !attention_out_n)
		else $error("attention not asserted while a flag is set");

	a_attn_high_clear: assert property (@(posedge clk) disable iff (!resetn)
		!(|temp_flags || |rail_flags || |main_flags) |=> attention_out_n)
		else $error("attention asserted with no flag set");

	a_temp_flag_set: assert property (@(posedge clk) disable iff (!resetn)
		(temp_cond != 8'h00) |=> ((temp_flags & $past(temp_cond)) == $past(temp_cond)))
		else $error("temperature flag failed to latch");

	a_rail_flag_set: assert property (@(posedge clk) disable iff (!resetn)
		(rail_cond != 8'h00) |=> ((rail_flags & $past(rail_cond)) == $past(rail_cond)))
		else $error("rail flag failed to latch");

	a_main_flag_set: assert property (@(posedge clk) disable iff (!resetn)
		main_rail_cond[3] |=> main_flags[3])
		else $error("general rail high alarm failed to latch");

	a_flag_sticks: assert property (@(posedge clk) disable iff (!resetn)
		(temp_flags[7] && !(rd_ev && ptr == MIR_OFS_TEMP_FLAGS)) |=> temp_flags[7])
		else $error("latched flag dropped without a read");

	a_flag_read_clear: assert property (@(posedge clk) disable iff (!resetn)
		(rd_ev && ptr == MIR_OFS_RAIL_FLAGS && rail_cond == 8'h00) |=> rail_flags == 8'h00)
		else $error("rail flags not cleared by read");

	a_main_read_clear: assert property (@(posedge clk) disable iff (!resetn)
		(rd_ev && ptr == MIR_OFS_MAIN_FLAGS && main_rail_cond == 4'h0) |=> main_flags == 4'h0)
		else $error("general rail flags not cleared by read");

	a_type_code: assert property (@(posedge clk) disable iff (!resetn)
		(ptr == MIR_OFS_TYPE_LO || ptr == MIR_OFS_TYPE_HI) |=> tx_byte == MODULE_TYPE)
		else $error("module type byte wrong");

	a_status_ready: assert property (@(posedge clk) disable iff (!resetn)
		(ptr == MIR_OFS_STATUS && $past(data_valid)) |=> tx_byte == 8'h00)
		else $error("status byte not ready with valid data");

	a_status_busy: assert property (@(posedge clk) disable iff (!resetn)
		(ptr == MIR_OFS_STATUS && !$past(data_valid)) |=> tx_byte == 8'h01)
		else $error("status byte not busy before valid data");

	a_top_temp_hi: assert property (@(posedge clk) disable iff (!resetn)
		(ptr == MIR_OFS_TOP_HI) |=> tx_byte == $past(top_temp[15:8], 2))
		else $error("top temperature high byte wrong");

	a_main_volt_lo: assert property (@(posedge clk) disable iff (!resetn)
		(ptr == MIR_OFS_MAIN_LO) |=> tx_byte == $past(main_rail_volt[7:0], 2))
		else $error("general rail low byte wrong");

	a_power_code: assert property (@(posedge clk) disable iff (!resetn)
		(ptr == MIR_OFS_MAX_POWER) |=> tx_byte == {4'h0, MAX_POWER_CODE, 2'h0})
		else $error("maximum power byte wrong");

	a_ptr_advance: assert property (@(posedge clk) disable iff (!resetn)
		(rd_ev && !start_det && !stop_det) |=> ptr == $past(ptr) + 8'h01)
		else $error("pointer did not advance after a read byte");

	a_frame_reset: assert property (@(posedge clk) disable iff (!resetn)
		(start_det || stop_det) |=> link_rst)
		else $error("link not reset on start or stop");

	a_lane_loop: assert property (@(posedge clk) disable iff (!resetn)
		(rx_lane_p == tx_lane_p) && (rx_lane_n == tx_lane_n))
		else $error("lane loop broken");
endmodule : mir_regs
`default_nettype wire

/* core/mir_sync.sv */
`default_nettype none
module mir_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,    // Destination clock.
	input  wire logic             resetn, // Asynchronous reset, active low.
	input  wire logic [WIDTH-1:0] d,      // Foreign-domain levels.
	output logic      [WIDTH-1:0] q       // Synchronised levels.
);
	logic [WIDTH-1:0] meta;

	if (WIDTH < 1) begin : g_chk
		$error("mir_sync needs WIDTH of at least one");
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : mir_sync
`default_nettype wire

/* test/mir_host.sv */
`default_nettype none
module mir_host (
	output logic       scl,      // Serial clock, high while the bus idles.
	output logic       sda_line, // Resolved data line level.
	input  wire logic  dev_oe,   // Device pull-down enable.
	input  wire logic  dev_out,  // Device drive value.
	output logic       got,      // Pulses once per byte read.
	output logic [7:0] rd_data   // Last byte read.
);
	timeunit 1ns;
	timeprecision 100ps;
	// Most frames run faster than 400 kHz to keep simulations short; a caller may slow it.
	realtime half;
	logic    pull;
	// The line has a pull-up, so it reads high whenever nobody pulls it.
	assign sda_line = ~(pull | (dev_oe & ~dev_out));
	initial begin
		half    = 100.0;
		scl     = 1'b1;
		pull    = 1'b0;
		got     = 1'b0;
		rd_data = 8'h00;
	end
	task automatic bit_cycle(input logic low, output logic seen);
		pull = low;
		#(half / 2);
		scl = 1'b1;
		#(half);
		seen = sda_line;
		scl = 1'b0;
		#(half / 2);
	endtask : bit_cycle
	// Serves as start and repeated start; the clock then stays low for 1 us.
	task automatic start();
		pull = 1'b0;
		#(half / 2 + 0.7);
		scl = 1'b1;
		#(half);
		pull = 1'b1;
		#(half);
		scl = 1'b0;
		#1000;
	endtask : start
	task automatic stop();
		pull = 1'b1;
		#(half / 2);
		scl = 1'b1;
		#(half);
		pull = 1'b0;
		#(half * 4);
	endtask : stop
	task automatic send(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_cycle(~b[i], s);
		bit_cycle(1'b0, s);
		ack = ~s;
	endtask : send
	// The last byte of a read is refused, which ends the device's drive.
	task automatic recv(input logic last);
		logic [7:0] b;
		logic       s;
		for (int i = 0; i < 8; i++) begin
			bit_cycle(1'b0, s);
			b = {b[6:0], s};
		end
		bit_cycle(~last, s);
		rd_data = b;
		got = 1'b1;
		#1;
		got = 1'b0;
	endtask : recv
endmodule : mir_host
`default_nettype wire

/* test/mir_regs_tb.sv */
`default_nettype none
module mir_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import mir_pkg::*;
	localparam logic [7:0]   TYPE_ID = 8'h3c; // Arbitrary value.
	localparam logic [127:0] NAME_T  = "TESTMAKER ALPHA ";
	localparam logic [127:0] PART_T  = "LOOP PART 0042 Q";
	localparam logic [15:0]  REV_T   = "B7";
	localparam logic [127:0] SER_T   = "SN7301ZX0000012Z";
	logic        clk, resetn, scl, sda_in, sda_out, sda_oe, attention_out_n, data_valid, got;
	logic [15:0] top_temp, bottom_temp, rx_rail_volt, tx_rail_volt, main_rail_volt;
	logic [7:0]  temp_cond, rail_cond, rd_data;
	logic [3:0]  main_rail_cond, tx_lane_p, tx_lane_n, rx_lane_p, rx_lane_n;
	int          failures, n_compared;
	logic [7:0]  exp_q[$];
	string       name_q[$];
	mir_regs #(.MODULE_TYPE(TYPE_ID), .MAX_POWER_CODE(MIR_PWR_3P5W), .MAKER_NAME(NAME_T),
		.MAKER_PART(PART_T), .MAKER_REV(REV_T), .SERIAL_NUMBER(SER_T)) dut (
		.clk(clk), .resetn(resetn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe(sda_oe), .attention_out_n(attention_out_n), .data_valid(data_valid),
		.top_temp(top_temp), .bottom_temp(bottom_temp), .rx_rail_volt(rx_rail_volt),
		.tx_rail_volt(tx_rail_volt), .main_rail_volt(main_rail_volt),
		.temp_cond(temp_cond), .rail_cond(rail_cond), .main_rail_cond(main_rail_cond),
		.tx_lane_p(tx_lane_p), .tx_lane_n(tx_lane_n), .rx_lane_p(rx_lane_p),
		.rx_lane_n(rx_lane_n));
	mir_host host (.scl(scl), .sda_line(sda_in), .dev_oe(sda_oe), .dev_out(sda_out),
		.got(got), .rd_data(rd_data));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic final_report();
		if (failures == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	task automatic note(input string n, input logic [7:0] v);
		exp_q.push_back(v);
		name_q.push_back(n);
	endtask : note
	task automatic expect_text(input string n, input logic [127:0] t, input int len);
		for (int i = 0; i < len; i++)
			note(n, t[127 - 8 * i -: 8]);
	endtask : expect_text
	task automatic rd(input logic [7:0] ptr, input int n);
		logic ack;
		host.start();
		host.send({MIR_DEV_ADDR, 1'b0}, ack);
		check("address_ack", {15'h0, ack}, 16'h1);
		host.send(ptr, ack);
		check("pointer_ack", {15'h0, ack}, 16'h1);
		host.start();
		host.send({MIR_DEV_ADDR, 1'b1}, ack);
		check("read_ack", {15'h0, ack}, 16'h1);
		for (int i = 0; i < n; i++)
			host.recv(i == n - 1);
		host.stop();
		@(negedge clk);
	endtask : rd
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		check("timeout", 16'h1, 16'h0);
		final_report();
	end
	always @(posedge got) begin
		if (exp_q.size() == 0) begin
			check("extra_byte", 16'h1, 16'h0);
		end else begin
			check(name_q.pop_front(), {8'h00, rd_data}, {8'h00, exp_q.pop_front()});
		end
	end
	initial begin
		logic [7:0]   tc, rc;
		logic [3:0]   mc;
		logic [127:0] mon;
		logic         ack;
		void'($urandom(32'h40516b16));
		{resetn, data_valid, temp_cond, rail_cond, main_rail_cond} = '0;
		{top_temp, bottom_temp, rx_rail_volt, tx_rail_volt, main_rail_volt} = '0;
		{tx_lane_p, tx_lane_n} = 8'h00;
		repeat (8) @(negedge clk);
		resetn = 1'b1;
		repeat (3) @(negedge clk);
		check("attention_idle", {15'h0, attention_out_n}, 16'h1);
		note("status_busy", 8'h01);
		rd(MIR_OFS_STATUS, 1);
		data_valid = 1'b1;
		top_temp = 16'h8000 | 16'($urandom);
		{bottom_temp, rx_rail_volt, tx_rail_volt, main_rail_volt} = {$urandom, $urandom};
		repeat (4) @(negedge clk);
		note("status_ready", 8'h00);
		rd(MIR_OFS_STATUS, 1);
		for (int i = 0; i < 8; i++) begin
			{tx_lane_p, tx_lane_n} = 8'($urandom);
			#1;
			check("lane_p", {12'h0, rx_lane_p}, {12'h0, tx_lane_p});
			check("lane_n", {12'h0, rx_lane_n}, {12'h0, tx_lane_n});
			@(negedge clk);
		end
		note("type_low", TYPE_ID);
		rd(MIR_OFS_TYPE_LO, 1);
		note("type_high", TYPE_ID);
		rd(MIR_OFS_TYPE_HI, 1);
		host.half = 1250.0;
		note("max_power", {4'h0, MIR_PWR_3P5W, 2'h0});
		rd(MIR_OFS_MAX_POWER, 1);
		host.half = 100.0;
		expect_text("maker_name", NAME_T, 16);
		rd(MIR_OFS_NAME, 16);
		expect_text("maker_part", PART_T, 16);
		expect_text("revision", {REV_T, 112'h0}, 2);
		rd(MIR_OFS_PART, 18);
		expect_text("serial", SER_T, 16);
		rd(MIR_OFS_SERIAL, 16);
		mon = {top_temp, bottom_temp, rx_rail_volt, tx_rail_volt, main_rail_volt, 48'h0};
		expect_text("monitor", mon, 10);
		rd(MIR_OFS_TOP_HI, 10);
		host.start();
		host.send({MIR_DEV_ADDR ^ 7'h01, 1'b0}, ack);
		check("foreign_ack", {15'h0, ack}, 16'h0);
		host.stop();
		host.start();
		host.send({MIR_DEV_ADDR, 1'b0}, ack);
		host.send(MIR_OFS_TYPE_LO, ack);
		host.send(8'hff, ack);
		check("data_ack", {15'h0, ack}, 16'h1);
		host.stop();
		@(negedge clk);
		note("type_kept", TYPE_ID);
		rd(MIR_OFS_TYPE_LO, 1);
		tc = 8'($urandom) | 8'h81;
		rc = 8'($urandom) | 8'h11;
		mc = 4'($urandom) | 4'h8;
		{temp_cond, rail_cond, main_rail_cond} = {tc, rc, mc};
		@(negedge clk);
		{temp_cond, rail_cond, main_rail_cond} = '0;
		repeat (3) @(negedge clk);
		check("attention_set", {15'h0, attention_out_n}, 16'h0);
		note("temp_flags", tc);
		rd(MIR_OFS_TEMP_FLAGS, 1);
		check("attention_held", {15'h0, attention_out_n}, 16'h0);
		note("rail_flags", rc);
		note("main_flags", {mc, 4'h0});
		rd(MIR_OFS_RAIL_FLAGS, 2);
		repeat (3) @(negedge clk);
		check("attention_free", {15'h0, attention_out_n}, 16'h1);
		for (int i = 0; i < 3; i++)
			note("flags_cleared", 8'h00);
		rd(MIR_OFS_TEMP_FLAGS, 3);
		check("pending", 16'(exp_q.size()), 16'h0);
		final_report();
	end
endmodule : mir_regs_tb
`default_nettype wire
